// ---- tic_pkg.sv ----
package tic_pkg;

  // Bus and datapath widths
  localparam int ADDR_W       = 6;
  localparam int DATA_W       = 32;
  localparam int BYTE_W       = 8;
  localparam int CNT_W        = 16;
  localparam int NUM_COUNTERS = 2;
  localparam int STATUS_W     = 2;
  localparam int PHASE_W      = 17;

  // Count source: fixed 2 MHz derived from the 125 MHz clock by phase accumulation
  localparam longint CLK_HZ        = 125_000_000;
  localparam longint SRC_HZ        = 2_000_000;
  localparam int     SRC_PERIOD_NS = 500;
  localparam logic [PHASE_W-1:0] PHASE_WRAP = PHASE_W'(CLK_HZ / 1000);
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(SRC_HZ / 1000);

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TIMER_CTL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CNT0      = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT1      = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_PPI_CTL   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ONE   = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_TWO   = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_MASK      = 6'h1C;

  // Interrupt control and status fields
  localparam int CT1_PORTA  = 0;
  localparam int CT2_SRC    = 0;
  localparam int CT2_CNT_EN = 1;
  localparam int CT2_MASTER = 2;
  localparam int ST_COUNTER = 0;
  localparam int ST_PORTA   = 1;
  localparam logic [STATUS_W-1:0] MASK_RESET = 2'h3;

  // Timer control word fields
  localparam int TW_SEL_HI  = 7;
  localparam int TW_SEL_LO  = 6;
  localparam int TW_RW_HI   = 5;
  localparam int TW_RW_LO   = 4;
  localparam int TW_MODE_HI = 3;
  localparam int TW_MODE_LO = 1;
  localparam logic [1:0] RW_LATCH   = 2'h0;
  localparam logic [1:0] RW_LSB     = 2'h1;
  localparam logic [1:0] RW_MSB     = 2'h2;
  localparam logic [1:0] RW_BOTH    = 2'h3;
  localparam logic [1:0] MODE_RATE  = 2'h2;
  localparam logic [CNT_W-1:0] COUNT_LAST = 16'h0001;
  localparam logic [CNT_W-1:0] COUNT_STEP = 16'h0001;

  // Parallel interface control word fields
  localparam int PPI_MODE_FLAG = 7;
  localparam int PPI_AMODE_HI  = 6;
  localparam int PPI_AMODE_LO  = 5;
  localparam int PPI_ADIR      = 4;
  localparam int PPI_BIT_HI    = 3;
  localparam int PPI_BIT_LO    = 1;
  localparam int PPI_SET       = 0;
  localparam logic [2:0] PC_OUT_BIT     = 3'h6;
  localparam logic [2:0] PC_IN_BIT      = 3'h4;
  localparam int         PC_REQ_BIT     = 3;
  localparam logic [1:0] AMODE_STROBED  = 2'h1;
  localparam int         AMODE_BIDIR    = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic input_full;
    logic output_empty;
  } porta_flags_type;

  typedef struct packed {
    logic                                aw_held;
    logic [ADDR_W-1:0]                   aw_addr;
    logic                                w_held;
    logic [BYTE_W-1:0]                   w_byte;
    logic                                w_lane;
    logic                                bvalid;
    logic [1:0]                          bresp;
    logic                                rvalid;
    logic [DATA_W-1:0]                   rdata;
    logic [1:0]                          rresp;
    logic [PHASE_W-1:0]                  phase;
    logic [BYTE_W-1:0]                   ctl_word;
    logic [NUM_COUNTERS-1:0][2:0]        mode;
    logic [NUM_COUNTERS-1:0][1:0]        rw;
    logic [NUM_COUNTERS-1:0]             running;
    logic [NUM_COUNTERS-1:0]             hi_next;
    logic [NUM_COUNTERS-1:0][CNT_W-1:0]  load;
    logic [NUM_COUNTERS-1:0][CNT_W-1:0]  count;
    logic [NUM_COUNTERS-1:0]             pulse;
    logic [1:0]                          pa_mode;
    logic                                pa_input;
    logic                                porta_output_irq_enable;
    logic                                porta_input_irq_enable;
    logic                                intra_prev;
    logic [BYTE_W-1:0]                   ctrl_one;
    logic [BYTE_W-1:0]                   ctrl_two;
    logic [STATUS_W-1:0]                 status;
    logic [STATUS_W-1:0]                 mask;
  } state_type;

endpackage

// ---- timer_interrupt_control.sv ----
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Contract
// - First counter steps once per period of a fixed 2 MHz source.
// - Only counters one and two work; third counter is ignored.
// - Gates tied high, so gate-triggered modes 1 and 5 never count.
// - First counter output clocks the second counter as a prescaler.
// - First counter pulses once every load value times 500 ns.
// - Second counter period is its load times the first counter period.
// - Control word 0x34 puts first counter in rate mode before loading.
// - Count loads low byte then high; counting starts after the high byte.
// - Control word 0x30 stops first counter; then interrupt control two cleared.
// - Writing 0x02 to control two enables counter irq from first counter.
// - Control two bit 0x04 is master enable; 0x06 keeps the source choice.
// - Writing 0x01 to control one enables port A interrupts.
// - Parallel mode word 0xC0 makes port A bidirectional, mode 2.
// - Bit set word 0x0D sets port C bit 6, output transfer irq enable.
// - Bit set word 0x09 sets port C bit 4, input transfer irq enable.
// - Input and output transfer requests merge into one port A request.
module timer_interrupt_control
  import tic_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]   s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire porta_flags_type       porta_flags,
  output logic                       counter_first_pulse,
  output logic                       counter_second_pulse,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State and derived terms

  localparam state_type ST_RESET = '{mask: MASK_RESET, default: '0};

  state_type                st_r;
  state_type                st_nxt;
  logic [PHASE_W-1:0]       phase_sum;
  logic                     tick;
  logic [NUM_COUNTERS-1:0]  cnt_step;
  logic [NUM_COUNTERS-1:0]  hit;
  logic                     wr_go;
  logic                     wr_en;
  logic [ADDR_W-1:0]        wr_off;
  logic [BYTE_W-1:0]        wr_byte;
  logic                     rd_go;
  logic                     in_ok;
  logic                     out_ok;
  logic                     intra;
  logic                     pa_event;
  logic                     cnt_event;
  logic [STATUS_W-1:0]      st_set;
  logic [STATUS_W-1:0]      st_clr;
  logic                     master_en;

  // Fractional divider: average tick rate is exactly 2 MHz
  assign phase_sum   = st_r.phase + PHASE_STEP;
  assign tick        = phase_sum >= PHASE_WRAP;
  assign cnt_step[0] = tick;
  assign cnt_step[1] = hit[0];
  assign hit[0]      = st_r.running[0] & cnt_step[0] & (st_r.count[0] == COUNT_LAST);
  assign hit[1]      = st_r.running[1] & cnt_step[1] & (st_r.count[1] == COUNT_LAST);

  assign wr_go   = st_r.aw_held & st_r.w_held & ~st_r.bvalid;
  assign wr_en   = wr_go & st_r.w_lane;
  assign wr_off  = st_r.aw_addr;
  assign wr_byte = st_r.w_byte;
  assign rd_go   = s_axi_arvalid & s_axi_arready;

  // Port A request: input and output transfer requests share one line
  assign in_ok  = st_r.pa_mode[AMODE_BIDIR] | ((st_r.pa_mode == AMODE_STROBED) & st_r.pa_input);
  assign out_ok = st_r.pa_mode[AMODE_BIDIR] | ((st_r.pa_mode == AMODE_STROBED) & ~st_r.pa_input);
  assign intra  = (in_ok & st_r.porta_input_irq_enable & porta_flags.input_full)
                | (out_ok & st_r.porta_output_irq_enable & porta_flags.output_empty);

  assign pa_event  = intra & ~st_r.intra_prev & st_r.ctrl_one[CT1_PORTA];
  assign cnt_event = st_r.ctrl_two[CT2_CNT_EN]
                   & (st_r.ctrl_two[CT2_SRC] ? hit[1] : hit[0]);
  assign master_en = st_r.ctrl_two[CT2_MASTER];

  always_comb begin
    st_set             = '0;
    st_set[ST_COUNTER] = cnt_event;
    st_set[ST_PORTA]   = pa_event;
  end

  assign st_clr = (rd_go && s_axi_araddr == OFF_STATUS) ? st_r.status : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0] sel;
    logic       idx;
    logic       start;
    logic [2:0] bit_idx;
    st_nxt  = st_r;
    sel     = '0;
    idx     = 1'b0;
    start   = 1'b0;
    bit_idx = '0;

    // Bus handshakes
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_byte = s_axi_wdata[BYTE_W-1:0];
      st_nxt.w_lane = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Count source and counters
    st_nxt.phase = tick ? phase_sum - PHASE_WRAP : phase_sum;
    st_nxt.pulse = hit;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (st_r.running[i] && cnt_step[i]) begin
        st_nxt.count[i] = hit[i] ? st_r.load[i] : st_r.count[i] - COUNT_STEP;
      end
    end

    // Register write
    if (wr_go) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = RESP_OKAY;
      case (wr_off)
        OFF_TIMER_CTL: begin
          sel = wr_byte[TW_SEL_HI:TW_SEL_LO];
          idx = sel[0];
          // Third counter and read-back selections do nothing
          if (!sel[1] && wr_byte[TW_RW_HI:TW_RW_LO] != RW_LATCH && wr_en) begin
            st_nxt.mode[idx]    = wr_byte[TW_MODE_HI:TW_MODE_LO];
            st_nxt.rw[idx]      = wr_byte[TW_RW_HI:TW_RW_LO];
            st_nxt.running[idx] = 1'b0;
            st_nxt.hi_next[idx] = 1'b0;
            if (!idx) begin
              st_nxt.ctl_word = wr_byte;
            end
          end
        end
        OFF_CNT0, OFF_CNT1: begin
          idx = (wr_off == OFF_CNT1);
          if (wr_en) begin
            case (st_r.rw[idx])
              RW_LSB: begin
                st_nxt.load[idx] = {{BYTE_W{1'b0}}, wr_byte};
                start            = 1'b1;
              end
              RW_MSB: begin
                st_nxt.load[idx] = {wr_byte, {BYTE_W{1'b0}}};
                start            = 1'b1;
              end
              RW_BOTH: begin
                if (!st_r.hi_next[idx]) begin
                  st_nxt.load[idx][BYTE_W-1:0] = wr_byte;
                  st_nxt.hi_next[idx]          = 1'b1;
                end else begin
                  st_nxt.load[idx][CNT_W-1:BYTE_W] = wr_byte;
                  st_nxt.hi_next[idx]              = 1'b0;
                  start                            = 1'b1;
                end
              end
              default: begin
                start = 1'b0;
              end
            endcase
            if (start) begin
              st_nxt.count[idx] = st_nxt.load[idx];
              // Gates are tied high: only the free-running rate mode can start
              st_nxt.running[idx] = (st_r.mode[idx][1:0] == MODE_RATE);
            end
          end
        end
        OFF_PPI_CTL: begin
          if (wr_en) begin
            if (wr_byte[PPI_MODE_FLAG]) begin
              st_nxt.pa_mode  = wr_byte[PPI_AMODE_HI:PPI_AMODE_LO];
              st_nxt.pa_input = wr_byte[PPI_ADIR];
              st_nxt.porta_output_irq_enable    = 1'b0;
              st_nxt.porta_input_irq_enable    = 1'b0;
            end else begin
              bit_idx = wr_byte[PPI_BIT_HI:PPI_BIT_LO];
              if (bit_idx == PC_OUT_BIT) begin
                st_nxt.porta_output_irq_enable = wr_byte[PPI_SET];
              end
              if (bit_idx == PC_IN_BIT) begin
                st_nxt.porta_input_irq_enable = wr_byte[PPI_SET];
              end
            end
          end
        end
        OFF_IRQ_ONE: begin
          if (wr_en) begin
            st_nxt.ctrl_one = wr_byte;
          end
        end
        OFF_IRQ_TWO: begin
          if (wr_en) begin
            st_nxt.ctrl_two = wr_byte;
          end
        end
        OFF_MASK: begin
          if (wr_en) begin
            st_nxt.mask = wr_byte[STATUS_W-1:0];
          end
        end
        OFF_STATUS: begin
          st_nxt.bresp = RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Register read
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = '0;
      case (s_axi_araddr)
        OFF_TIMER_CTL: st_nxt.rdata[BYTE_W-1:0]   = st_r.ctl_word;
        OFF_CNT0:      st_nxt.rdata[CNT_W-1:0]    = st_r.count[0];
        OFF_CNT1:      st_nxt.rdata[CNT_W-1:0]    = st_r.count[1];
        OFF_PPI_CTL: begin
          st_nxt.rdata[PC_OUT_BIT] = st_r.porta_output_irq_enable;
          st_nxt.rdata[PC_IN_BIT]  = st_r.porta_input_irq_enable;
          st_nxt.rdata[PC_REQ_BIT] = intra;
        end
        OFF_IRQ_ONE:   st_nxt.rdata[BYTE_W-1:0]   = st_r.ctrl_one;
        OFF_IRQ_TWO:   st_nxt.rdata[BYTE_W-1:0]   = st_r.ctrl_two;
        OFF_STATUS:    st_nxt.rdata[STATUS_W-1:0] = st_r.status;
        OFF_MASK:      st_nxt.rdata[STATUS_W-1:0] = st_r.mask;
        default:       st_nxt.rresp               = RESP_SLVERR;
      endcase
    end

    // Sticky status: a new event wins over the read clear
    st_nxt.intra_prev = intra;
    st_nxt.status     = (st_r.status & ~st_clr) | st_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready        = ~st_r.aw_held & ~st_r.bvalid;
  assign s_axi_wready         = ~st_r.w_held & ~st_r.bvalid;
  assign s_axi_bvalid         = st_r.bvalid;
  assign s_axi_bresp          = st_r.bresp;
  assign s_axi_arready        = ~st_r.rvalid;
  assign s_axi_rvalid         = st_r.rvalid;
  assign s_axi_rdata          = st_r.rdata;
  assign s_axi_rresp          = st_r.rresp;
  assign counter_first_pulse  = st_r.pulse[0];
  assign counter_second_pulse = st_r.pulse[1];
  assign irq                  = master_en & |(st_r.status & st_r.mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  src_spacing_a: assert property (tick |=> !tick [*8])
    else $error("count source ticks too close together");

  third_ignored_a: assert property (wr_en && wr_off == OFF_TIMER_CTL
    && wr_byte[TW_SEL_HI] |=> $stable(st_r.mode) && $stable(st_r.running))
    else $error("third counter selection changed counter state");

  gated_idle_a: assert property (st_r.running[0] |->
    st_r.mode[0][1:0] != 2'h1)
    else $error("gate-triggered mode is counting");

  cascade_step_a: assert property (st_r.pulse[1] |-> st_r.pulse[0])
    else $error("second counter stepped without first counter pulse");

  first_reload_a: assert property (hit[0] && !wr_go |=>
    st_r.count[0] == st_r.load[0] && st_r.pulse[0])
    else $error("first counter did not reload on terminal count");

  rate_word_a: assert property (wr_en && wr_off == OFF_TIMER_CTL
    && wr_byte == 8'h34 |=> st_r.mode[0][1:0] == MODE_RATE && !st_r.running[0])
    else $error("rate mode word not taken by first counter");

  high_start_a: assert property (wr_en && wr_off == OFF_CNT0 && st_r.rw[0] == RW_BOTH
    && st_r.hi_next[0] && st_r.mode[0][1:0] == MODE_RATE |=> st_r.running[0])
    else $error("counter did not start after high byte");

  stop_word_a: assert property (wr_en && wr_off == OFF_TIMER_CTL
    && wr_byte == 8'h30 |=> !st_r.running[0] ##1 !st_r.pulse[0])
    else $error("stop word left first counter running");

  master_block_a: assert property (!master_en |-> !irq)
    else $error("interrupt raised with master enable clear");

  irq_follow_a: assert property (master_en && (st_r.status & st_r.mask) != '0 |-> irq)
    else $error("unmasked status did not raise interrupt");

  bit_six_a: assert property (wr_en && wr_off == OFF_PPI_CTL
    && wr_byte == 8'h0D |=> st_r.porta_output_irq_enable)
    else $error("bit set word did not enable output transfer request");

  bit_four_a: assert property (wr_en && wr_off == OFF_PPI_CTL
    && wr_byte == 8'h09 |=> st_r.porta_input_irq_enable)
    else $error("bit set word did not enable input transfer request");

  porta_merge_a: assert property (pa_event |=> st_r.status[ST_PORTA])
    else $error("port A request lost");

  ppi_bidir_a: assert property (wr_en && wr_off == OFF_PPI_CTL && wr_byte == 8'hC0
    |=> st_r.pa_mode[AMODE_BIDIR] && !st_r.porta_output_irq_enable && !st_r.porta_input_irq_enable)
    else $error("bidirectional mode word not taken by port A");

  first_step_a: assert property (st_r.running[0] && tick && !wr_go
    && st_r.count[0] != COUNT_LAST
    |=> st_r.count[0] == $past(st_r.count[0]) - COUNT_STEP)
    else $error("first counter did not step on a count source tick");

  second_reload_a: assert property (hit[1] && !wr_go |=>
    st_r.count[1] == st_r.load[1] && st_r.pulse[1])
    else $error("second counter did not reload on terminal count");

  second_hold_a: assert property (!hit[0] && !wr_go |=> $stable(st_r.count[1]))
    else $error("second counter moved without a first counter pulse");

  cnt_status_a: assert property (cnt_event |=> st_r.status[ST_COUNTER])
    else $error("counter event did not set status");

  status_read_a: assert property (rd_go && s_axi_araddr == OFF_STATUS
    && !st_set[ST_PORTA] |=> !st_r.status[ST_PORTA])
    else $error("status read did not clear the port A bit");

  cnt_irq_c: cover property (cnt_event ##[1:300] irq);
  cascade_c: cover property (hit[1]);
  porta_irq_c: cover property (pa_event ##1 irq);
  status_clear_c: cover property (rd_go && s_axi_araddr == OFF_STATUS && st_r.status != '0);
  porta_bidir_c: cover property (in_ok && out_ok && intra);

endmodule // timer_interrupt_control

// ---- porta_buffer_model.sv ----
`timescale 1ns/1ps
module porta_buffer_model
  import tic_pkg::*;
(
  input  wire logic clk,
  output porta_flags_type flags
);
  logic in_full_req   = 1'b0;
  logic out_empty_req = 1'b0;
  logic in_full_r     = 1'b0;
  logic out_empty_r   = 1'b0;

  assign flags = {in_full_r, out_empty_r};

  // A requested level reaches the buffer flag at the next clock edge
  always @(posedge clk) begin
    in_full_r   <= in_full_req;
    out_empty_r <= out_empty_req;
  end

  task automatic set_input_full(input logic v);
    in_full_req <= v;
  endtask

  task automatic set_output_empty(input logic v);
    out_empty_req <= v;
  endtask
endmodule // porta_buffer_model

// ---- timer_interrupt_control_test.sv ----
`timescale 1ns/1ps
module timer_interrupt_control_test;
  import tic_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        wstrb = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, p1, p2, irq;
  logic [1:0]        bresp, rresp;
  logic [DATA_W-1:0] rdata;
  porta_flags_type   flags;
  int                errors = 0;
  int                compares = 0;

  always #4 clk = ~clk;

  timer_interrupt_control timer_interrupt_control_inst (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .porta_flags(flags), .counter_first_pulse(p1), .counter_second_pulse(p2), .irq(irq));

  porta_buffer_model porta_buffer_model_inst (.clk(clk), .flags(flags));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("Comparisons %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ap = 1'b1;
    logic wp = 1'b1;
    awaddr <= a; wdata <= {24'h000000, d}; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (ap || wp) begin
      @(posedge clk);
      if (ap && awready === 1'b1) begin ap = 1'b0; awvalid <= 1'b0; end
      if (wp && wready === 1'b1) begin wp = 1'b0; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    // Response ready stays high between calls
    check($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    check($sformatf("rdata %h", a), e, rdata);
    check($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("irq", 0, irq);
    rd(OFF_MASK, 32'h00000003, RESP_OKAY);
    rd(OFF_IRQ_TWO, 32'h00000000, RESP_OKAY);
  endtask

  task automatic t_bus;
    wr(6'h20, 8'h55, RESP_SLVERR);
    rd(6'h24, 32'h00000000, RESP_SLVERR);
    wr(OFF_STATUS, 8'h03, RESP_OKAY);
    rd(OFF_STATUS, 32'h00000000, RESP_OKAY);
  endtask

  task automatic t_counter_irq;
    int n = 0;
    wr(OFF_IRQ_ONE, 8'h00, RESP_OKAY);
    wr(OFF_IRQ_TWO, 8'h00, RESP_OKAY);
    wr(OFF_TIMER_CTL, 8'h34, RESP_OKAY);
    wr(OFF_IRQ_TWO, 8'h02, RESP_OKAY);
    wr(OFF_IRQ_TWO, 8'h06, RESP_OKAY);
    wr(OFF_CNT0, 8'h04, RESP_OKAY);
    wr(OFF_CNT0, 8'h00, RESP_OKAY);
    do @(posedge clk); while (p1 !== 1'b1);
    do begin @(posedge clk); n++; end while (p1 !== 1'b1);
    check("first gap", 4 * SRC_PERIOD_NS / 8, n);
    cycles(2);
    check("irq", 1, irq);
    rd(OFF_STATUS, 32'h00000001, RESP_OKAY);
    check("irq", 0, irq);
  endtask

  task automatic t_prescale;
    int n = 0;
    wr(OFF_TIMER_CTL, 8'h74, RESP_OKAY);
    wr(OFF_CNT1, 8'h03, RESP_OKAY);
    wr(OFF_CNT1, 8'h00, RESP_OKAY);
    do @(posedge clk); while (p2 !== 1'b1);
    do begin @(posedge clk); if (p1 === 1'b1) n++; end while (p2 !== 1'b1);
    check("first per second", 3, n);
    check("first at second", 1, p1);
  endtask

  task automatic t_stop_modes;
    int n = 0;
    logic [7:0] ctl [2] = '{8'h32, 8'h3A};
    wr(OFF_TIMER_CTL, 8'h30, RESP_OKAY);
    wr(OFF_IRQ_TWO, 8'h00, RESP_OKAY);
    check("irq", 0, irq);
    rd(OFF_STATUS, 32'h00000001, RESP_OKAY);
    foreach (ctl[i]) begin
      wr(OFF_TIMER_CTL, ctl[i], RESP_OKAY);
      wr(OFF_CNT0, 8'h04, RESP_OKAY);
      wr(OFF_CNT0, 8'h00, RESP_OKAY);
      repeat (600) begin @(posedge clk); if (p1 === 1'b1 || p2 === 1'b1) n++; end
      check("gated pulses", 0, n);
    end
    wr(OFF_TIMER_CTL, 8'h30, RESP_OKAY);
    wr(OFF_TIMER_CTL, 8'hB4, RESP_OKAY);
    rd(OFF_TIMER_CTL, 32'h00000030, RESP_OKAY);
  endtask

  task automatic t_porta;
    wr(OFF_PPI_CTL, 8'hC0, RESP_OKAY);
    wr(OFF_PPI_CTL, 8'h0D, RESP_OKAY);
    wr(OFF_IRQ_TWO, 8'h04, RESP_OKAY);
    wr(OFF_IRQ_ONE, 8'h01, RESP_OKAY);
    porta_buffer_model_inst.set_output_empty(1'b1);
    cycles(3);
    check("irq", 1, irq);
    rd(OFF_PPI_CTL, 32'h00000048, RESP_OKAY);
    rd(OFF_STATUS, 32'h00000002, RESP_OKAY);
    check("irq", 0, irq);
    porta_buffer_model_inst.set_output_empty(1'b0);
    wr(OFF_PPI_CTL, 8'h0C, RESP_OKAY);
    porta_buffer_model_inst.set_input_full(1'b1);
    cycles(3);
    check("irq", 0, irq);
    wr(OFF_PPI_CTL, 8'h09, RESP_OKAY);
    cycles(3);
    check("irq", 1, irq);
    rd(OFF_PPI_CTL, 32'h00000018, RESP_OKAY);
    wr(OFF_IRQ_TWO, 8'h00, RESP_OKAY);
    check("irq", 0, irq);
    wr(OFF_IRQ_TWO, 8'h04, RESP_OKAY);
    check("irq", 1, irq);
    wr(OFF_MASK, 8'h00, RESP_OKAY);
    check("irq", 0, irq);
    wr(OFF_MASK, 8'h03, RESP_OKAY);
    check("irq", 1, irq);
    rd(OFF_STATUS, 32'h00000002, RESP_OKAY);
    check("irq", 0, irq);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bus();
    t_counter_irq();
    t_prescale();
    t_stop_modes();
    t_porta();
    results();
  end

  // Whole run needs some 3300 cycles
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("Watchdog expired");
    results();
  end
endmodule // timer_interrupt_control_test
